/* File: src/spa_align.sv */
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module spa_align (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire spa_pkg::spa_addr_t wb_adr_i,
    input  wire spa_pkg::spa_word_t wb_dat_i,
    output spa_pkg::spa_word_t     wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              sysref_i,
    output logic                   local_multiframe_clock_o,
    output logic                   irq_o
);
    import spa_pkg::*;

    function automatic spa_meas_t measure(input logic [LOCAL_MULTIFRAME_CLOCK_W-1:0] cnt, input logic [1:0] win);
        spa_meas_t m;
        logic signed [4:0] e;
        logic signed [4:0] w;
        m       = MEAS_ZERO;
        e       = signed'({cnt[LOCAL_MULTIFRAME_CLOCK_W-1], cnt});
        w       = signed'({3'b000, win});
        m.err   = signed'(cnt);
        m.below = (e < -w);
        m.above = (e > w);
        return m;
    endfunction : measure

    spa_state_t       state;
    spa_state_t       next_state;
    spa_byte_t        window_reg;
    spa_byte_t        control;
    spa_byte_t        control_prev;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [LOCAL_MULTIFRAME_CLOCK_W-1:0] local_multiframe_clock_cnt;
    logic [LOCAL_MULTIFRAME_CLOCK_W-1:0] next_cnt;
    spa_meas_t        meas;
    spa_meas_t        present;
    spa_meas_t        previous;
    logic             armed;
    logic             lock;
    logic             wlim;
    logic             rotated;
    logic             tripped;

    // Bus decode
    wire        bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
    wire        bus_rd    = bus_req & ~wb_we_i;
    wire [7:0]  bus_idx   = wb_adr_i[9:2];
    wire        wr_window = bus_wr & (bus_idx == IDX_WINDOW);
    wire        wr_ctrl   = bus_wr & (bus_idx == IDX_CONTROL);
    wire        wr_mask   = bus_wr & (bus_idx == IDX_IRQ_MASK);
    wire        rd_istat  = bus_rd & (bus_idx == IDX_IRQ_STAT);

    // Control decode
    wire [1:0]  tol_win      = window_reg[1:0];
    wire [3:0]  mode         = control[3:0];
    wire        enabled      = control[CTL_EN];
    wire        arm_rise     = control[CTL_ARM] & ~control_prev[CTL_ARM];
    wire        clr_stk_rise = control[CTL_CLRSTK] & ~control_prev[CTL_CLRSTK];
    wire        clr_prv_rise = control[CTL_CLRPREV] & ~control_prev[CTL_CLRPREV];
    wire        mode_one     = (mode == MODE_ONESHOT) | (mode == MODE_ONE_MON);
    wire        mode_cont    = (mode == MODE_CONT);
    wire        mode_mon     = (mode == MODE_MONITOR) | (mode == MODE_ONE_MON);

    logic sr_rise;

    spa_edge_sync u_sysref (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (sysref_i),
        .rise_o (sr_rise)
    );

    // Measurement and adjustment decisions
    wire       meas_take  = sr_rise & ((state == SPA_WAIT) | (state == SPA_MONITOR));
    spa_meas_t meas_now;
    assign     meas_now   = measure(local_multiframe_clock_cnt, tol_win);
    wire       meas_out   = meas.below | meas.above;
    wire       do_adjust  = (state == SPA_EVAL) & meas_out;
    wire       trip_set   = sr_rise & (state == SPA_WAIT) & armed;
    wire       busy       = (state == SPA_WAIT) | (state == SPA_EVAL);
    wire       lock_gain  = enabled & ~lock & ((meas_take & ~(meas_now.below | meas_now.above)) | do_adjust);
    wire       wlim_set   = meas_take & (meas_now.below | meas_now.above);

    wire [IRQ_W-1:0] irq_set = {lock_gain, do_adjust, wlim_set, trip_set};

    // State machine
    always_comb begin
        next_state = state;
        case (state)
            SPA_IDLE: begin
                if (enabled & arm_rise & mode_one) begin
                    next_state = SPA_WAIT;
                end else if (enabled & mode_cont) begin
                    next_state = SPA_WAIT;
                end else if (enabled & (mode == MODE_MONITOR)) begin
                    next_state = SPA_MONITOR;
                end
            end
            SPA_WAIT: begin
                if (!enabled) begin
                    next_state = SPA_IDLE;
                end else if (sr_rise) begin
                    next_state = SPA_EVAL;
                end
            end
            SPA_EVAL: begin
                if (enabled & mode_cont) begin
                    next_state = SPA_WAIT;
                end else if (enabled & (mode == MODE_ONE_MON)) begin
                    next_state = SPA_MONITOR;
                end else begin
                    next_state = SPA_IDLE;
                end
            end
            SPA_MONITOR: begin
                if (!enabled | !mode_mon) begin
                    next_state = SPA_IDLE;
                end else if (arm_rise & (mode == MODE_ONE_MON)) begin
                    next_state = SPA_WAIT;
                end
            end
            default: next_state = SPA_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= SPA_IDLE;
            armed <= 1'b0;
        end else begin
            state <= next_state;
            if (next_state == SPA_WAIT && arm_rise) begin
                armed <= 1'b1;
            end else if (state == SPA_EVAL || !enabled) begin
                armed <= 1'b0;
            end
        end
    end

    // Local multiframe clock, realigned on an adjustment
    assign next_cnt = do_adjust ? LOCAL_MULTIFRAME_CLOCK_RELOAD : local_multiframe_clock_cnt + LOCAL_MULTIFRAME_CLOCK_STEP;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            local_multiframe_clock_cnt <= LOCAL_MULTIFRAME_CLOCK_ZERO;
            local_multiframe_clock_o   <= 1'b0;
        end else begin
            local_multiframe_clock_cnt <= next_cnt;
            local_multiframe_clock_o   <= (next_cnt == LOCAL_MULTIFRAME_CLOCK_ZERO);
        end
    end

    // Error records
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meas     <= MEAS_ZERO;
            present  <= MEAS_ZERO;
            previous <= MEAS_ZERO;
        end else begin
            if (meas_take) begin
                meas    <= meas_now;
                present <= meas_now;
            end
            if (do_adjust) begin
                present  <= MEAS_ZERO;
                previous <= meas;
            end else if (clr_prv_rise) begin
                previous <= MEAS_ZERO;
            end
        end
    end

    // Status flags; a set wins over a sticky clear in the same cycle, but a disable clears lock even when set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock    <= 1'b0;
            wlim    <= 1'b0;
            rotated <= 1'b0;
            tripped <= 1'b0;
        end else begin
            if (!enabled) begin
                lock <= 1'b0;
            end else if (do_adjust) begin
                lock <= 1'b1;
            end else if (meas_take) begin
                lock <= ~(meas_now.below | meas_now.above);
            end
            if (meas_take) begin
                wlim <= meas_now.below | meas_now.above;
            end
            rotated <= do_adjust | (rotated & ~clr_stk_rise);
            tripped <= trip_set | (tripped & ~clr_stk_rise);
        end
    end

    // Registers written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            window_reg   <= RST_BYTE;
            control      <= RST_BYTE;
            control_prev <= RST_BYTE;
            irq_mask     <= '0;
        end else begin
            control_prev <= control;
            if (wr_window) begin
                window_reg <= {6'h00, wb_dat_i[1:0]};
            end
            if (wr_ctrl) begin
                control <= wb_dat_i[7:0];
            end
            if (wr_mask) begin
                irq_mask <= wb_dat_i[IRQ_W-1:0];
            end
        end
    end

    // Interrupt status clears on read, new events win
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= irq_set | (rd_istat ? '0 : irq_stat);
        end
    end

    wire [IRQ_W-1:0] next_irq = irq_set | (rd_istat ? '0 : irq_stat);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(next_irq & irq_mask);
        end
    end

    // Read mux; status reads leave every flag untouched
    wire spa_byte_t status_byte = {busy, 3'b000, lock, rotated, wlim, tripped};
    spa_byte_t rd_byte;

    always_comb begin
        case (bus_idx)
            IDX_IRQ_STAT: rd_byte = {4'h0, irq_stat};
            IDX_IRQ_MASK: rd_byte = {4'h0, irq_mask};
            IDX_WINDOW:   rd_byte = window_reg;
            IDX_PREV_L:   rd_byte = {4'h0, previous.err};
            IDX_PREV_H:   rd_byte = {previous.below, previous.above, 6'h00};
            IDX_CONTROL:  rd_byte = control;
            IDX_STATUS:   rd_byte = status_byte;
            IDX_PRES_L:   rd_byte = {4'h0, present.err};
            IDX_PRES_H:   rd_byte = {present.below, present.above, 6'h00};
            default:      rd_byte = RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_rd) begin
                wb_dat_o <= {24'h000000, rd_byte};
            end
        end
    end

    // Checks
    sequence s_armed_sysref;
        (state == SPA_WAIT) && armed && sr_rise;
    endsequence

    sequence s_outside_eval;
        (state == SPA_EVAL) && meas_out;
    endsequence

    busy_on_arm_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == SPA_IDLE) && enabled && arm_rise && mode_one |=> status_byte[ST_BUSY] ##1 status_byte[ST_BUSY])
        else $error("busy not raised after arming");

    lock_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        meas_take && enabled && !(meas_now.below || meas_now.above) |=> status_byte[ST_LOCK])
        else $error("lock not set for in-window error");

    rotate_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_armed_sysref ##1 s_outside_eval |=> rotated && local_multiframe_clock_cnt == LOCAL_MULTIFRAME_CLOCK_RELOAD)
        else $error("rotation not recorded");

    wlim_track_a: assert property (@(posedge clk_i) disable iff (rst_i)
        meas_take |=> wlim == ($past(meas_now.below) || $past(meas_now.above)))
        else $error("window limit flag wrong");

    trip_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_armed_sysref |=> tripped [*2])
        else $error("trip flag not held");

    adjust_move_a: assert property (@(posedge clk_i) disable iff (rst_i)
        do_adjust |=> previous == $past(meas) && present.err == 4'sh0)
        else $error("adjustment did not move error");

    window_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == SPA_EVAL) && !meas_out |=> local_multiframe_clock_cnt == $past(local_multiframe_clock_cnt) + LOCAL_MULTIFRAME_CLOCK_STEP)
        else $error("clock shifted inside window");

    below_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        meas_take |=> present.below == ($past(signed'(local_multiframe_clock_cnt)) < -$past(signed'({3'b000, tol_win}))))
        else $error("below flag wrong");

    clear_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
        clr_stk_rise && !do_adjust && !trip_set |=> !rotated && !tripped)
        else $error("sticky clear failed");

    read_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_rd && bus_idx == IDX_STATUS && !clr_stk_rise && rotated |=> rotated)
        else $error("status read changed a flag");

    ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse");

endmodule : spa_align

/* File: common/spa_pkg.sv */
package spa_pkg;

    typedef logic [9:0]  spa_addr_t;
    typedef logic [31:0] spa_word_t;
    typedef logic [7:0]  spa_byte_t;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_IRQ_STAT = 8'h30;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
    localparam logic [7:0] IDX_WINDOW   = 8'h34;
    localparam logic [7:0] IDX_PREV_L   = 8'h38;
    localparam logic [7:0] IDX_PREV_H   = 8'h39;
    localparam logic [7:0] IDX_CONTROL  = 8'h3a;
    localparam logic [7:0] IDX_STATUS   = 8'h3b;
    localparam logic [7:0] IDX_PRES_L   = 8'h3c;
    localparam logic [7:0] IDX_PRES_H   = 8'h3d;

    // alignment_status fields
    localparam int ST_BUSY = 7;
    localparam int ST_LOCK = 3;
    localparam int ST_ROT  = 2;
    localparam int ST_WLIM = 1;
    localparam int ST_TRIP = 0;

    // Control register fields
    localparam int CTL_EN      = 7;
    localparam int CTL_ARM     = 6;
    localparam int CTL_CLRSTK  = 5;
    localparam int CTL_CLRPREV = 4;

    // Error flag fields of the high error registers
    localparam int FLG_BELOW = 7;
    localparam int FLG_ABOVE = 6;

    // Interrupt status and mask fields
    localparam int IRQ_TRIP = 0;
    localparam int IRQ_WLIM = 1;
    localparam int IRQ_ROT  = 2;
    localparam int IRQ_LOCK = 3;
    localparam int IRQ_W    = 4;

    localparam logic [3:0] MODE_ONESHOT  = 4'h1;
    localparam logic [3:0] MODE_CONT     = 4'h2;
    localparam logic [3:0] MODE_MONITOR  = 4'h8;
    localparam logic [3:0] MODE_ONE_MON  = 4'h9;

    localparam spa_byte_t RST_BYTE = 8'h00;
    localparam int        LOCAL_MULTIFRAME_CLOCK_W   = 4;
    localparam logic [LOCAL_MULTIFRAME_CLOCK_W-1:0] LOCAL_MULTIFRAME_CLOCK_ZERO   = 4'h0;
    localparam logic [LOCAL_MULTIFRAME_CLOCK_W-1:0] LOCAL_MULTIFRAME_CLOCK_STEP   = 4'h1;
    // Counter value two cycles after the sampled edge, so the edge lands on zero
    localparam logic [LOCAL_MULTIFRAME_CLOCK_W-1:0] LOCAL_MULTIFRAME_CLOCK_RELOAD = 4'h2;

    typedef struct packed {
        logic signed [3:0] err;
        logic              below;
        logic              above;
    } spa_meas_t;

    localparam spa_meas_t MEAS_ZERO = '0;

    typedef enum logic [1:0] {
        SPA_IDLE,
        SPA_WAIT,
        SPA_EVAL,
        SPA_MONITOR
    } spa_state_t;

endpackage : spa_pkg

/* File: src/spa_edge_sync.sv */
`timescale 1ns/1ps
module spa_edge_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      rise_o
);
    import spa_pkg::*;

    logic meta;
    logic stable;
    logic last;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta   <= 1'b0;
            stable <= 1'b0;
            last   <= 1'b0;
        end else begin
            meta   <= pin_i;
            stable <= meta;
            last   <= stable;
        end
    end

    assign rise_o = stable & ~last;

endmodule : spa_edge_sync

/* File: sim/spa_sysref_gen.sv */
`timescale 1ns/1ps
module spa_sysref_gen (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       fire_i,
    input  wire logic [3:0] delay_i,
    output logic            sysref_o,
    output logic            done_o
);
    logic [4:0] cnt;

    // Pulse starts delay_i+1 clocks after the edge that takes the fire request, two clocks wide
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 5'h00;
        end else if (fire_i) begin
            cnt <= {1'h0, delay_i} + 5'h03;
        end else if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
        end
    end

    assign sysref_o = (cnt == 5'h02) || (cnt == 5'h01);
    assign done_o   = (cnt == 5'h00);
endmodule : spa_sysref_gen

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import spa_pkg::*;
    logic       clk_i     = 1'h0;
    logic       rst_i     = 1'h1;
    logic       wb_cyc_i  = 1'h0;
    logic       wb_stb_i  = 1'h0;
    logic       wb_we_i   = 1'h0;
    logic [3:0] wb_sel_i  = 4'hf;
    spa_addr_t  wb_adr_i  = '0;
    spa_word_t  wb_dat_i  = '0;
    spa_word_t  wb_dat_o;
    logic       wb_ack_o;
    logic       sysref_i;
    logic       local_multiframe_clock_o;
    logic       irq_o;
    logic       fire      = 1'h0;
    logic [3:0] dly       = 4'h0;
    logic       done;
    // Error for a pulse fired right after a marker: fire, pulse start, two sync flops, edge
    localparam logic [3:0] e0 = 4'h5;
    spa_byte_t  v;
    int         n_fail    = 0;
    int         cmp_count = 0;

    always #25 clk_i = ~clk_i;

    spa_align spa_align_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sysref_i(sysref_i), .local_multiframe_clock_o(local_multiframe_clock_o),
        .irq_o(irq_o)
    );

    spa_sysref_gen spa_sysref_gen_i (
        .clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .delay_i(dly),
        .sysref_o(sysref_i), .done_o(done)
    );

    task automatic print_verdict();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task automatic bail();
        n_fail++;
        print_verdict();
    endtask : bail

    task automatic check(input spa_byte_t seen, input spa_byte_t exp, input spa_byte_t id);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: item %h got %h want %h", $time, id, seen, exp);
        end
    endtask : check

    // Classic cycle; ack and read data are taken as sampled at the edge
    task automatic wb(input logic we, input logic [7:0] idx, input spa_byte_t wd);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'h0};
        wb_dat_i <= {24'h0, wd};
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'h1) break;
        end
        if (i == 20) bail();
        v = wb_dat_o[7:0];
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : wb

    task automatic wr(input logic [7:0] idx, input spa_byte_t d);
        wb(1'h1, idx, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input spa_byte_t m, input spa_byte_t exp);
        wb(1'h0, idx, 8'h00);
        check(v & m, exp, idx);
    endtask : rd_chk

    // Fires a pulse k+3 clocks after the start of a multiframe marker, waits for it to be judged
    task automatic shot(input logic [3:0] k);
        int i;
        @(posedge clk_i);
        for (i = 0; local_multiframe_clock_o !== 1'h1; i++) begin
            if (i > 40) bail();
            @(posedge clk_i);
        end
        fire <= 1'h1;
        dly  <= k;
        @(posedge clk_i);
        fire <= 1'h0;
        // Done is still high at the edge that takes the request
        @(posedge clk_i);
        for (i = 0; done !== 1'h1; i++) begin
            if (i > 40) bail();
            @(posedge clk_i);
        end
        repeat (5) @(posedge clk_i);
    endtask : shot

    task automatic shot_err(input logic [3:0] t);
        shot(t - e0);
    endtask : shot_err

    task automatic measure();
        wr(IDX_CONTROL, 8'h08);
        wr(IDX_CONTROL, 8'h88);
        wr(IDX_CONTROL, 8'hc8);
        shot(4'h0);
        wb(1'h0, IDX_PRES_L, 8'h00);
        check({4'h0, v[3:0]}, {4'h0, e0}, IDX_PRES_L);
    endtask : measure

    task automatic s_reset();
        int n;
        rd_chk(IDX_STATUS, 8'hff, RST_BYTE);
        rd_chk(IDX_PRES_L, 8'hff, RST_BYTE);
        rd_chk(IDX_PRES_H, 8'hff, RST_BYTE);
        rd_chk(8'h3e, 8'hff, 8'h00);
        wr(IDX_STATUS, 8'hff);
        rd_chk(IDX_STATUS, 8'hff, RST_BYTE);
        check({7'h0, irq_o}, 8'h00, 8'hff);
        // Marker period spans the full counter range of sixteen clocks
        @(posedge clk_i);
        for (n = 0; local_multiframe_clock_o !== 1'h1; n++) begin
            if (n > 40) bail();
            @(posedge clk_i);
        end
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (local_multiframe_clock_o !== 1'h1 && n < 40);
        check(8'(n), 8'h10, 8'hfe);
    endtask : s_reset

    // Window of one: errors of 1 and -1 inside, 2 and -2 outside
    task automatic s_monitor();
        logic [3:0] tv [4] = '{4'h1, 4'h2, 4'he, 4'hf};
        spa_byte_t  fl [4] = '{8'h00, 8'h40, 8'h80, 8'h00};
        wr(IDX_WINDOW, 8'h01);
        measure();
        rd_chk(IDX_PRES_L, 8'hf0, 8'h00);
        shot(4'h1);
        rd_chk(IDX_PRES_L, 8'hff, {4'h0, e0 + 4'h1});
        foreach (tv[j]) begin
            shot_err(tv[j]);
            rd_chk(IDX_PRES_L, 8'hff, {4'h0, tv[j]});
            rd_chk(IDX_PRES_H, 8'hc0, fl[j]);
            rd_chk(IDX_STATUS, 8'h06, {6'h00, fl[j] != 8'h00, 1'h0});
        end
    endtask : s_monitor

    task automatic s_oneshot();
        wr(IDX_CONTROL, 8'h08);
        wr(IDX_IRQ_MASK, 8'h04);
        wb(1'h0, IDX_IRQ_STAT, 8'h00);
        wr(IDX_CONTROL, 8'h81);
        wr(IDX_CONTROL, 8'hc1);
        rd_chk(IDX_STATUS, 8'h8c, 8'h80);
        check({7'h0, irq_o}, 8'h00, 8'hff);
        shot_err(4'hd);
        rd_chk(IDX_STATUS, 8'h8d, 8'h0d);
        rd_chk(IDX_PRES_L, 8'h0f, 8'h00);
        rd_chk(IDX_PREV_L, 8'h0f, 8'h0d);
        rd_chk(IDX_PREV_H, 8'hc0, 8'h80);
        check({7'h0, irq_o}, 8'h01, 8'hff);
        rd_chk(IDX_IRQ_STAT, 8'h0d, 8'h0d);
        repeat (2) @(posedge clk_i);
        check({7'h0, irq_o}, 8'h00, 8'hff);
        rd_chk(IDX_STATUS, 8'h05, 8'h05);
        wr(IDX_CONTROL, 8'ha1);
        rd_chk(IDX_STATUS, 8'h05, 8'h00);
    endtask : s_oneshot

    task automatic s_modes();
        measure();
        wr(IDX_CONTROL, 8'h02);
        wr(IDX_CONTROL, 8'h82);
        rd_chk(IDX_STATUS, 8'h80, 8'h80);
        shot_err(4'h3);
        rd_chk(IDX_STATUS, 8'h04, 8'h04);
        rd_chk(IDX_PREV_L, 8'h0f, 8'h03);
        measure();
        wr(IDX_CONTROL, 8'h29);
        wr(IDX_CONTROL, 8'h89);
        wr(IDX_CONTROL, 8'hc9);
        shot_err(4'hf);
        rd_chk(IDX_STATUS, 8'h0c, 8'h08);
        shot_err(4'h2);
        rd_chk(IDX_PRES_L, 8'h0f, 8'h02);
        rd_chk(IDX_PREV_L, 8'h0f, 8'h03);
    endtask : s_modes

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        s_reset();
        s_monitor();
        s_oneshot();
        s_modes();
        print_verdict();
    end
endmodule : tb_top
